/* scc_clock_ctrl.sv */
// SYSREF clock-control registers behind the serial configuration port
module scc_clock_ctrl #(
    parameter int SAMPLE_W = scc_pkg::SCC_SAMPLE_W,
    parameter int TAPS     = scc_pkg::SCC_TAPS
) (
    // Clock, reset, enable
    input  wire logic                        ref_clk_in,
    input  wire logic                        resetn_in,
    input  wire logic                        ce_in,
    // Serial configuration port
    input  wire logic                        spi_sclk_in,
    input  wire logic                        spi_cs_n_in,
    input  wire logic                        spi_sdi_in,
    output logic                             spi_sdo_out,
    output logic                             spi_sdo_oe_out,
    // SYSREF pin and converter context
    input  wire logic                        sysref_in,
    input  wire logic                        output_timestamp_on_in,
    input  wire logic                        ddc_bypass_in,
    // Sample path
    input  wire logic                        sample_valid_in,
    input  wire logic [SAMPLE_W-1:0]         sample_data_in,
    output logic                             sample_valid_out,
    output logic [SAMPLE_W-1:0]              sample_data_out,
    // SYSREF processing
    output logic                             sysref_event_out,
    output logic                             sysref_receiver_on_out,
    output logic                             sysref_processor_on_out,
    // Analog clock controls
    output logic                             device_clock_dc_input_mode_out,
    output logic                             sysref_dc_input_mode_out,
    output logic                             clock_feedback_gain_out,
    output logic                             analog_supply_noise_suppress_out,
    output logic [scc_pkg::SCC_CLKDEL_W-1:0] sampling_clock_delay_trim_out
);
    import scc_pkg::*;

    localparam int SEL_W = $clog2(TAPS);

    typedef struct packed {
        // Pin synchronisers: [0] first stage, read only by [1]
        logic [2:0]              sclk_sync;
        logic [1:0]              cs_sync;
        logic [1:0]              sdi_sync;
        logic [1:0]              sref_sync;
        // Serial port
        scc_spi_state_type       spi_state;
        logic [3:0]              bitcnt;
        logic [15:0]             shift;
        logic                    rw;
        logic [14:0]             addr;
        logic [7:0]              rd_byte;
        logic                    sdo;
        logic                    sdo_oe;
        // Registers
        logic [7:0]              capture_ctrl;
        logic [7:0]              input_ctrl;
        logic [7:0]              trim_ctrl;
        logic [SCC_POS_W-1:0]    edge_position;
        // SYSREF path
        logic [SCC_POS_W-1:0]    history;
        logic                    half;
        logic                    sr_prev;
        logic                    dly_prev;
        logic                    event_pulse;
        // Outputs
        logic                    valid;
        logic [SAMPLE_W-1:0]     data;
        logic                    recv_on;
        logic                    proc_on;
        logic                    devclk_dc;
        logic                    sref_dc;
        logic                    fb_gain;
        logic                    noise_suppr;
        logic [SCC_CLKDEL_W-1:0] clk_del;
    } scc_state_type;

    scc_state_type st_reg;
    scc_state_type st_next;

    logic       cs_active;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sdi_bit;
    logic       sr_gated;
    logic       sr_rise;
    logic       sr_delayed;
    logic [2:0] out_idx;
    logic [7:0] wr_byte;
    logic [14:0] hdr_addr;
    logic [14:0] addr_inc;

    ////////////////////////////////////////////////////////////////////////
    // Register read map; unmapped addresses read zero

    function automatic logic [7:0] scc_read(input scc_state_type s, input logic [14:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            SCC_ADDR_CAPTURE: r = s.capture_ctrl;
            SCC_ADDR_INPUT:   r = s.input_ctrl;
            SCC_ADDR_TRIM:    r = s.trim_ctrl;
            SCC_ADDR_POS0:    r = s.edge_position[7:0];
            SCC_ADDR_POS1:    r = s.edge_position[15:8];
            SCC_ADDR_POS2:    r = s.edge_position[23:16];
            default:          r = 8'h00;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Combinational helpers

    assign cs_active = !st_reg.cs_sync[1];
    assign sclk_rise = st_reg.sclk_sync[1] && !st_reg.sclk_sync[2];
    assign sclk_fall = !st_reg.sclk_sync[1] && st_reg.sclk_sync[2];
    assign sdi_bit   = st_reg.sdi_sync[1];
    assign out_idx   = 3'd7 - st_reg.bitcnt[2:0];
    assign wr_byte   = {st_reg.shift[6:0], sdi_bit};
    assign hdr_addr  = {st_reg.shift[13:0], sdi_bit};
    assign addr_inc  = st_reg.addr + 15'h0001;

    // Receiver off forces a quiet SYSREF; inversion ahead of alignment
    assign sr_gated = st_reg.capture_ctrl[SCC_RECV_BIT]
                      && (st_reg.sref_sync[1] ^ st_reg.input_ctrl[SCC_INVERT_BIT]);
    assign sr_rise  = sr_gated && !st_reg.sr_prev;

    scc_tap_delay #(
        .TAPS (TAPS)
    ) u_tap_delay (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .fine_in    (st_reg.capture_ctrl[SCC_ZOOM_BIT]),
        .sel_in     (st_reg.capture_ctrl[SCC_SEL_LSB +: SEL_W]),
        .d_in       (sr_gated),
        .q_out      (sr_delayed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;
        if (ce_in) begin
            st_next.sclk_sync = {st_reg.sclk_sync[1:0], spi_sclk_in};
            st_next.cs_sync   = {st_reg.cs_sync[0], spi_cs_n_in};
            st_next.sdi_sync  = {st_reg.sdi_sync[0], spi_sdi_in};
            st_next.sref_sync = {st_reg.sref_sync[0], sysref_in};

            // Serial port: 16-bit header (R/W, address) then data bytes
            if (!cs_active) begin
                st_next.spi_state = SCC_HDR;
                st_next.bitcnt    = 4'h0;
                st_next.sdo       = 1'b0;
                st_next.sdo_oe    = 1'b0;
            end else begin
                if (sclk_rise) begin
                    st_next.shift  = {st_reg.shift[14:0], sdi_bit};
                    st_next.bitcnt = st_reg.bitcnt + 4'h1;
                    unique case (st_reg.spi_state)
                        SCC_HDR: begin
                            if (st_reg.bitcnt == 4'(SCC_HDR_BITS - 1)) begin
                                st_next.rw        = st_reg.shift[14];
                                st_next.addr      = hdr_addr;
                                st_next.rd_byte   = scc_read(st_reg, hdr_addr);
                                st_next.spi_state = SCC_DATA;
                                st_next.bitcnt    = 4'h0;
                            end
                        end
                        SCC_DATA: begin
                            if (st_reg.bitcnt == 4'(SCC_DATA_BITS - 1)) begin
                                // Streaming moves to the next address
                                if (!st_reg.rw) begin
                                    unique case (st_reg.addr)
                                        SCC_ADDR_CAPTURE: st_next.capture_ctrl = wr_byte;
                                        SCC_ADDR_INPUT:   st_next.input_ctrl   = wr_byte;
                                        SCC_ADDR_TRIM:    st_next.trim_ctrl    = wr_byte;
                                        default:          st_next.bitcnt       = 4'h0;
                                    endcase
                                end
                                st_next.addr    = addr_inc;
                                st_next.rd_byte = scc_read(st_reg, addr_inc);
                                st_next.bitcnt  = 4'h0;
                            end
                        end
                    endcase
                end
                // Read data shifts out on falling edges, MSB first
                if (sclk_fall && st_reg.spi_state == SCC_DATA && st_reg.rw) begin
                    st_next.sdo    = st_reg.rd_byte[out_idx];
                    st_next.sdo_oe = 1'b1;
                end
            end

            // Position history; coarse scale advances every second cycle
            st_next.half    = !st_reg.half;
            st_next.sr_prev = sr_gated;
            if (st_reg.capture_ctrl[SCC_ZOOM_BIT] || st_reg.half) begin
                st_next.history = {st_reg.history[SCC_POS_W-2:0], sr_gated};
            end
            if (sr_rise) begin
                st_next.edge_position = st_reg.history;
            end

            // Processor acts on delayed SYSREF rising edges only when enabled
            st_next.dly_prev    = sr_delayed;
            st_next.event_pulse = st_reg.capture_ctrl[SCC_PROC_BIT]
                                  && sr_delayed && !st_reg.dly_prev;

            // Sample path with optional SYSREF timestamp in the LSB
            st_next.valid = sample_valid_in;
            st_next.data  = sample_data_in;
            if (st_reg.input_ctrl[SCC_TS_BIT] && output_timestamp_on_in
                && ddc_bypass_in) begin
                st_next.data[0] = sr_delayed;
            end

            st_next.recv_on     = st_reg.capture_ctrl[SCC_RECV_BIT];
            st_next.proc_on     = st_reg.capture_ctrl[SCC_PROC_BIT];
            st_next.devclk_dc   = st_reg.input_ctrl[SCC_DEVCLK_DC_BIT];
            st_next.sref_dc     = st_reg.input_ctrl[SCC_SREF_DC_BIT];
            st_next.fb_gain     = st_reg.trim_ctrl[SCC_FB_GAIN_BIT];
            st_next.noise_suppr = st_reg.trim_ctrl[SCC_NOISE_BIT];
            st_next.clk_del     = st_reg.trim_ctrl[SCC_CLKDEL_LSB +: SCC_CLKDEL_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg               <= '0;
            st_reg.spi_state     <= SCC_HDR;
            st_reg.sclk_sync     <= 3'h0;
            st_reg.cs_sync       <= 2'h3;
            st_reg.capture_ctrl  <= SCC_RST_CAPTURE;
            st_reg.input_ctrl    <= SCC_RST_INPUT;
            st_reg.trim_ctrl     <= SCC_RST_TRIM;
            st_reg.edge_position <= SCC_RST_POS;
            st_reg.fb_gain       <= SCC_RST_TRIM[SCC_FB_GAIN_BIT];
            st_reg.clk_del       <= SCC_RST_TRIM[SCC_CLKDEL_LSB +: SCC_CLKDEL_W];
        end else begin
            st_reg <= st_next;
        end
    end

    assign spi_sdo_out                      = st_reg.sdo;
    assign spi_sdo_oe_out                   = st_reg.sdo_oe;
    assign sample_valid_out                 = st_reg.valid;
    assign sample_data_out                  = st_reg.data;
    assign sysref_event_out                 = st_reg.event_pulse;
    assign sysref_receiver_on_out           = st_reg.recv_on;
    assign sysref_processor_on_out          = st_reg.proc_on;
    assign device_clock_dc_input_mode_out   = st_reg.devclk_dc;
    assign sysref_dc_input_mode_out         = st_reg.sref_dc;
    assign clock_feedback_gain_out          = st_reg.fb_gain;
    assign analog_supply_noise_suppress_out = st_reg.noise_suppr;
    assign sampling_clock_delay_trim_out    = st_reg.clk_del;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_sref_rise;
        ce_in && sr_rise;
    endsequence

    sequence s_stamp_on;
        ce_in && st_reg.input_ctrl[SCC_TS_BIT] && output_timestamp_on_in && ddc_bypass_in;
    endsequence

    AST_NO_EVENT_WHEN_OFF: assert property (
        ce_in && !st_reg.capture_ctrl[SCC_PROC_BIT] |=> !sysref_event_out)
        else $error("SYSREF event raised while the processor is off");

    AST_RECV_QUIET: assert property (
        ce_in && !st_reg.capture_ctrl[SCC_RECV_BIT] |-> !sr_gated ##1 !sysref_receiver_on_out)
        else $error("SYSREF passes while the receiver is off");

    AST_COARSE_HOLD: assert property (
        ce_in && !st_reg.capture_ctrl[SCC_ZOOM_BIT] && !st_reg.half |=> $stable(st_reg.history))
        else $error("Coarse position history moved on a hold cycle");

    AST_STAMP_LSB: assert property (
        s_stamp_on |=> sample_data_out[0] == $past(sr_delayed))
        else $error("Sample LSB does not carry SYSREF");

    AST_NO_STAMP_DDC: assert property (
        ce_in && !ddc_bypass_in |=> sample_data_out == $past(sample_data_in))
        else $error("Sample altered while the downconverter is active");

    AST_INVERT: assert property (
        st_reg.capture_ctrl[SCC_RECV_BIT] && st_reg.input_ctrl[SCC_INVERT_BIT]
        |-> sr_gated == !st_reg.sref_sync[1])
        else $error("SYSREF not inverted");

    AST_DEVCLK_MODE: assert property (
        ce_in ##1 ce_in |=> device_clock_dc_input_mode_out == $past(st_reg.input_ctrl[SCC_DEVCLK_DC_BIT]))
        else $error("Device clock input mode does not follow its bit");

    AST_SREF_MODE: assert property (
        ce_in |=> sysref_dc_input_mode_out == $past(st_reg.input_ctrl[SCC_SREF_DC_BIT]))
        else $error("SYSREF input mode does not follow its bit");

    AST_POS_CAPTURE: assert property (
        s_sref_rise |=> st_reg.edge_position == $past(st_reg.history))
        else $error("Edge position not captured on a SYSREF rise");

endmodule

/* scc_pkg.sv */
// Shared constants and types for the SYSREF clock-control register block
package scc_pkg;

    // Register addresses on the serial configuration port
    localparam logic [14:0] SCC_ADDR_CAPTURE = 15'h0029;
    localparam logic [14:0] SCC_ADDR_INPUT   = 15'h002a;
    localparam logic [14:0] SCC_ADDR_TRIM    = 15'h002b;
    localparam logic [14:0] SCC_ADDR_POS0    = 15'h002c;
    localparam logic [14:0] SCC_ADDR_POS1    = 15'h002d;
    localparam logic [14:0] SCC_ADDR_POS2    = 15'h002e;

    // Reset values
    localparam logic [7:0]  SCC_RST_CAPTURE  = 8'h00;
    localparam logic [7:0]  SCC_RST_INPUT    = 8'h00;
    localparam logic [7:0]  SCC_RST_TRIM     = 8'h11;
    localparam logic [23:0] SCC_RST_POS      = 24'h000000;

    // sysref_capture_ctrl fields
    localparam int SCC_PROC_BIT     = 6;
    localparam int SCC_RECV_BIT     = 5;
    localparam int SCC_ZOOM_BIT     = 4;
    localparam int SCC_SEL_LSB      = 0;
    localparam int SCC_SEL_W        = 4;

    // sysref_input_and_timestamp_ctrl fields
    localparam int SCC_TS_BIT       = 3;
    localparam int SCC_DEVCLK_DC_BIT = 2;
    localparam int SCC_SREF_DC_BIT  = 1;
    localparam int SCC_INVERT_BIT   = 0;

    // sampling_clock_trim_ctrl fields
    localparam int SCC_FB_GAIN_BIT  = 4;
    localparam int SCC_NOISE_BIT    = 2;
    localparam int SCC_CLKDEL_LSB   = 0;
    localparam int SCC_CLKDEL_W     = 2;

    // Status, serial frame, delay line and sample sizes
    localparam int SCC_POS_W        = 24;
    localparam int SCC_HDR_BITS     = 16;
    localparam int SCC_DATA_BITS    = 8;
    localparam int SCC_TAPS         = 16;
    localparam int SCC_SAMPLE_W     = 16;

    typedef enum logic {
        SCC_HDR,
        SCC_DATA
    } scc_spi_state_type;

endpackage

/* scc_tap_delay.sv */
// Selectable SYSREF capture delay line with coarse and fine step scale
module scc_tap_delay #(
    parameter int TAPS = scc_pkg::SCC_TAPS
) (
    // Clock, reset and enable
    input  wire logic                   ref_clk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   ce_in,
    // Control
    input  wire logic                   fine_in,
    input  wire logic [$clog2(TAPS)-1:0] sel_in,
    // Data
    input  wire logic                   d_in,
    output logic                        q_out
);
    import scc_pkg::*;

    localparam int LEN = 2 * TAPS;

    typedef struct packed {
        logic [LEN-1:0] line;
        logic           q;
    } scc_tap_state_type;

    scc_tap_state_type st_reg;
    scc_tap_state_type st_next;
    logic [LEN-1:0]    line_shift;

    // One stage per position of the line
    genvar g;
    generate
        for (g = 0; g < LEN; g++) begin : g_line
            if (g == 0) begin : g_head
                assign line_shift[g] = d_in;
            end else begin : g_body
                assign line_shift[g] = st_reg.line[g-1];
            end
        end
    endgenerate

    always_comb begin
        st_next = st_reg;
        if (ce_in) begin
            st_next.line = line_shift;
            // Fine scale steps one cycle per tap, coarse two
            if (fine_in) begin
                st_next.q = st_reg.line[sel_in];
            end else begin
                st_next.q = st_reg.line[{sel_in, 1'b1}];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.q;

    AST_TAP_SELECT: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && fine_in |=> q_out == $past(st_reg.line[sel_in]))
        else $error("Fine tap output does not follow the selected stage");

endmodule

/* scc_spi_host.sv */
// Host controller model driving the serial configuration port
module scc_spi_host (
    // Clock
    input  wire logic ref_clk_in,
    // Serial port
    input  wire logic spi_sdo_in,
    output logic      spi_sclk_out,
    output logic      spi_cs_n_out,
    output logic      spi_sdi_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_sclk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_sdi_out  = 1'b0;
    end
    // Six ref cycles per phase keeps clear of the synchroniser limit
    task automatic half();
        repeat (6) @(negedge ref_clk_in);
    endtask
    task automatic shift(input logic b, output logic s);
        spi_sdi_out = b;
        half();
        s = spi_sdo_in;
        spi_sclk_out = 1'b1;
        half();
        spi_sclk_out = 1'b0;
    endtask
    // Short nbits leaves a partial byte, which aborts the frame
    task automatic xfer(input logic rw, input logic [14:0] a, input int nbits,
                        input logic [23:0] wd, output logic [23:0] rd);
        logic [15:0] hdr;
        logic        s;
        int          idx;
        hdr = {rw, a};
        rd = 24'h000000;
        @(negedge ref_clk_in);
        spi_cs_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) shift(hdr[i], s);
        for (int b = 0; b < nbits; b++) begin
            idx = 8 * (b / 8) + 7 - b % 8;
            shift(wd[idx], s);
            rd[idx] = s;
        end
        half();
        spi_cs_n_out = 1'b1;
        // Released line must not keep showing the last bit
        spi_sdi_out = ~spi_sdi_out;
        half();
    endtask
endmodule

/* test_sysref_clock_control_regs.sv */
// Self-checking bench for the SYSREF clock-control register block
module test_sysref_clock_control_regs;
    import scc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [14:0] a; logic [7:0] d; logic [7:0] o;} scc_row_type;
    // Outputs packed as recv, proc, dev_dc, sref_dc, gain, noise, trim
    localparam scc_row_type ROWS [7] = '{'{15'h2a, 8'h04, 8'h29}, '{15'h2a, 8'h02, 8'h19},
        '{15'h2b, 8'h04, 8'h14}, '{15'h2b, 8'h12, 8'h1a}, '{15'h2a, 8'h00, 8'h0a},
        '{15'h29, 8'h20, 8'h8a}, '{15'h29, 8'h60, 8'hca}};
    logic        ref_clk, resetn, ce, sclk, cs_n, sdi, sref, ts_on, bypass;
    logic [15:0] s_data;
    wire logic   sdo, sdo_oe, v_out, ev, recv, proc, dev_dc, sref_dc, gain, noise;
    wire logic [15:0] d_out;
    wire logic [1:0]  trim;
    logic [23:0] rd, pos;
    int          mismatches, compares, n1, n2;
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    scc_clock_ctrl u_scc_clock_ctrl (.ref_clk_in(ref_clk), .resetn_in(resetn), .ce_in(ce),
        .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
        .spi_sdo_oe_out(sdo_oe), .sysref_in(sref), .output_timestamp_on_in(ts_on),
        .ddc_bypass_in(bypass), .sample_valid_in(1'b1), .sample_data_in(s_data),
        .sample_valid_out(v_out), .sample_data_out(d_out), .sysref_event_out(ev),
        .sysref_receiver_on_out(recv), .sysref_processor_on_out(proc),
        .device_clock_dc_input_mode_out(dev_dc), .sysref_dc_input_mode_out(sref_dc),
        .clock_feedback_gain_out(gain), .analog_supply_noise_suppress_out(noise),
        .sampling_clock_delay_trim_out(trim));
    scc_spi_host u_scc_spi_host (.ref_clk_in(ref_clk), .spi_sdo_in(sdo), .spi_sclk_out(sclk),
        .spi_cs_n_out(cs_n), .spi_sdi_out(sdi));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        u_scc_spi_host.xfer(1'b0, a, 8, {16'h0000, d}, rd);
    endtask
    task automatic rb(input logic [14:0] a, input int nbits);
        u_scc_spi_host.xfer(1'b1, a, nbits, 24'h000000, rd);
    endtask
    // Cycles from a pin level change to the event pulse, -1 if none
    task automatic lat_of(input logic lvl, output int n);
        n = -1;
        @(negedge ref_clk);
        sref = lvl;
        for (int i = 1; i < 48; i++) begin
            @(negedge ref_clk);
            if (ev === 1'b1 && n < 0) n = i;
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic reset_check();
        resetn = 1'b0;
        repeat (20) @(negedge ref_clk);
        chk("reset outputs", 24'h09, {recv, proc, dev_dc, sref_dc, gain, noise, trim});
        resetn = 1'b1;
        rb(SCC_ADDR_CAPTURE, 24);
        chk("reset regs", 24'h110000, rd);
    endtask
    initial begin
        {ce, sref, ts_on, bypass} = 4'b1000;
        s_data = 16'h0000;
        reset_check();
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            chk("outputs", {16'h0, ROWS[i].o}, {recv, proc, dev_dc, sref_dc, gain, noise, trim});
            rb(ROWS[i].a, 8);
            chk("readback", {16'h0, ROWS[i].d}, rd);
        end
        lat_of(1'b1, n1);
        lat_of(1'b0, n2);
        chk("event on rise", 24'h1, 24'(n1 > 0));
        chk("no event on fall", 24'h1, 24'(n2 < 0));
        wr(SCC_ADDR_CAPTURE, 8'h63);
        lat_of(1'b1, n2);
        chk("coarse tap later", 24'h1, 24'(n2 > n1));
        lat_of(1'b0, n1);
        wr(SCC_ADDR_CAPTURE, 8'h73);
        lat_of(1'b1, n1);
        chk("fine steps shorter", 24'h1, 24'(n1 > 0 && n1 < n2));
        lat_of(1'b0, n1);
        wr(SCC_ADDR_CAPTURE, 8'h20);
        lat_of(1'b1, n1);
        chk("processor off", 24'h1, 24'(n1 < 0));
        wr(SCC_ADDR_CAPTURE, 8'h60);
        wr(SCC_ADDR_INPUT, 8'h01);
        lat_of(1'b0, n1);
        chk("inverted event", 24'h1, 24'(n1 > 0));
        wr(SCC_ADDR_INPUT, 8'h08);
        {ts_on, bypass} = 2'b11;
        s_data = 16'h1231;
        repeat (30) @(negedge ref_clk);
        chk("stamp low", 24'h1230, {8'h00, d_out});
        chk("valid copy", 24'h1, {23'h0, v_out});
        {sref, s_data} = {1'b1, 16'h1230};
        repeat (30) @(negedge ref_clk);
        chk("stamp high", 24'h1231, {8'h00, d_out});
        bypass = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("no stamp decimating", 24'h1230, {8'h00, d_out});
        {ts_on, bypass} = 2'b01;
        repeat (4) @(negedge ref_clk);
        chk("no stamp disabled", 24'h1230, {8'h00, d_out});
        // Enable low must hold the sample register still
        {ce, s_data} = {1'b0, 16'h4321};
        repeat (8) @(negedge ref_clk);
        chk("frozen sample", 24'h1230, {8'h00, d_out});
        ce = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("thawed sample", 24'h4321, {8'h00, d_out});
        rb(SCC_ADDR_POS0, 24);
        pos = rd;
        u_scc_spi_host.xfer(1'b0, SCC_ADDR_POS0, 24, 24'ha5a5a5, rd);
        rb(SCC_ADDR_POS0, 24);
        chk("position read only", pos, rd);
        // Data phase of the read is well under way by cycle 240
        fork
            rb(SCC_ADDR_CAPTURE, 24);
            begin
                repeat (240) @(negedge ref_clk);
                chk("sdo enable", 24'h1, {23'h0, sdo_oe});
            end
        join
        chk("streaming read", 24'h120860, rd);
        chk("sdo released", 24'h0, {23'h0, sdo_oe});
        u_scc_spi_host.xfer(1'b0, SCC_ADDR_TRIM, 4, 24'h0000ff, rd);
        rb(SCC_ADDR_TRIM, 8);
        chk("aborted write", 24'h12, rd);
        wr(15'h0040, 8'hff);
        rb(15'h0040, 8);
        chk("unmapped", 24'h00, rd);
        reset_check();
        wrap_up();
    end
endmodule
